// File: gpp_top.sv
`timescale 1ns/1ns
`include "gpp_cfg.svh"

// Notes on behaviour
// - first port direction 1 floats pin
// - direction 0 drives latch onto pin
// - first port has six pins, own bits
// - data read gives pins, write hits latch
// - port writes without byte lane load sampled pins
// - count clock pin drives low only
// - analog pins reset analog, read zero
// - converter config selects analog or digital
// - direction still acts on analog pins
// - enabled peripheral takes its pin over
// - bit five doubles as serial select
// - second port has switchable weak pull-ups
// - upper four bits flag change, read resyncs reference
// - bit zero edge sets sticky ext flag
// - flags set regardless of enable bits
// - interrupt control holds five enables, three flags
module gpp_top
  import gpp_pkg::*;
#(
  parameter bit HasConverter = 1'b1       // variant with the analog converter
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          srst,
  // wishbone classic slave
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [11:0]   wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  // package pins
  input  wire gpp_pins_in_t  pinsIn,
  output gpp_pins_out_t      pinsOut,
  // peripheral side
  input  wire logic          count0WrapEvt,
  input  wire logic          periphIrqPend,
  output logic               sharedCountClock,
  output logic               serialSelectN,
  output logic               irqReq
);

  gpp_state_t s_q;                        // registered state
  gpp_state_t s_d;                        // next state
  logic [5:0] analogMask;                 // first port pins in analog use
  logic [5:0] openDrainMask;              // pins with pull-low-only drivers
  logic [5:0] periphMask;                 // pins owned by a peripheral
  logic [5:0] aRead;                      // first port read value
  logic [7:0] regIdx;                     // word index of the access
  logic       reqNew;                     // request not yet answered
  logic       reqDone;                    // edge at which ack is high
  logic [7:0] rdMux;                      // read data before registering
  logic       extEdge;                    // qualifying edge on ext pin
  logic       chgSeen;                    // mismatch on upper second port
  logic [7:0] intNext;                    // interrupt control after write

  assign regIdx  = wb_adr_i[9:2];
  assign reqNew  = wb_cyc_i && wb_stb_i && !s_q.ack;
  assign reqDone = wb_cyc_i && wb_stb_i && s_q.ack;

  // converter config picks analog pins; bit four never analog
  always_comb begin
    case (s_q.convCfg)
      3'h0, 3'h1: analogMask = 6'h2F;
      3'h2, 3'h3: analogMask = 6'h0F;
      3'h4, 3'h5: analogMask = 6'h0B;
      default:    analogMask = 6'h00;
    endcase
    if (!HasConverter) begin
      analogMask = 6'h00;
    end
  end

  // pin roles on the first port
  always_comb begin
    openDrainMask = 6'h00;
    openDrainMask[`GPP_PA_COUNT_CLK] = 1'b1;
    periphMask = 6'h00;
    // counter clock source in use makes the pin an input
    periphMask[`GPP_PA_COUNT_CLK]  = s_q.opt[`GPP_OPT_COUNT_SRC];
    // serial port enabled owns the select pin as its input
    periphMask[`GPP_PA_SERIAL_SEL] = s_q.periphCtl[`GPP_PC_SERIAL_EN];
  end

  // one cell per first port pin
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_pa
      gpp_pin_cell u_cell (
        .dir       (s_q.dirA[gi]),
        .latch     (s_q.latA[gi]),
        .analog    (analogMask[gi]),
        .openDrain (openDrainMask[gi]),
        .periphOwn (periphMask[gi]),
        .pinIn     (pinsIn.a[gi]),
        .pinOut    (pinsOut.a[gi]),
        .pinOe     (pinsOut.aOe[gi]),
        .rdVal     (aRead[gi])
      );
    end
  endgenerate

  // second port drivers and weak pull-ups; plain assigns since the cells drive other members
  assign pinsOut.b   = s_q.latB;
  assign pinsOut.bOe = ~s_q.dirB;
  // pull-up only while enabled and the pin is an input
  assign pinsOut.bPull = s_q.opt[`GPP_OPT_PULL_DIS_N] ? 8'h00 : s_q.dirB;

  // peripheral inputs taken from shared pins
  assign sharedCountClock = pinsIn.a[`GPP_PA_COUNT_CLK];
  assign serialSelectN    = pinsIn.a[`GPP_PA_SERIAL_SEL];

  // edge and change detection on the second port
  always_comb begin
    if (s_q.opt[`GPP_OPT_EDGE_SEL]) begin
      extEdge = pinsIn.b[0] && !s_q.extPrev;
    end else begin
      extEdge = !pinsIn.b[0] && s_q.extPrev;
    end
    // only pins set as inputs take part in the comparison
    chgSeen = |((pinsIn.b[7:4] ^ s_q.chgRef) & s_q.dirB[7:4]);
  end

  // read multiplexer; unmapped words read as zero
  always_comb begin
    case (regIdx)
      `GPP_IDX_FIRST_PINS:  rdMux = {2'h0, aRead};
      `GPP_IDX_SECOND_PINS: rdMux = pinsIn.b;
      `GPP_IDX_INT_CTL:     rdMux = s_q.intCtl;
      `GPP_IDX_OPTIONS:     rdMux = s_q.opt;
      `GPP_IDX_FIRST_DIR:   rdMux = {2'h0, s_q.dirA};
      `GPP_IDX_SECOND_DIR:  rdMux = s_q.dirB;
      `GPP_IDX_CONV_CFG:    rdMux = {5'h00, s_q.convCfg};
      `GPP_IDX_PERIPH_CTL:  rdMux = s_q.periphCtl;
      default:              rdMux = 8'h00;
    endcase
  end

  // next state: bus access, then hardware events on top
  always_comb begin
    s_d = s_q;
    // ack goes high one cycle after a new request and lasts one cycle
    s_d.ack = reqNew;
    if (reqNew) begin
      s_d.rdat = rdMux;
    end
    s_d.extPrev = pinsIn.b[0];
    intNext = s_q.intCtl;
    // writes land at the edge where ack is seen high
    if (reqDone && wb_we_i && wb_sel_i[0]) begin
      case (regIdx)
        // the written byte replaces the whole latch
        `GPP_IDX_FIRST_PINS:  s_d.latA = wb_dat_i[5:0];
        `GPP_IDX_SECOND_PINS: s_d.latB = wb_dat_i[7:0];
        `GPP_IDX_INT_CTL:     intNext = wb_dat_i[7:0];
        `GPP_IDX_OPTIONS:     s_d.opt = wb_dat_i[7:0];
        `GPP_IDX_FIRST_DIR:   s_d.dirA = wb_dat_i[5:0];
        `GPP_IDX_SECOND_DIR:  s_d.dirB = wb_dat_i[7:0];
        `GPP_IDX_CONV_CFG:    s_d.convCfg = wb_dat_i[2:0];
        `GPP_IDX_PERIPH_CTL:  s_d.periphCtl = wb_dat_i[7:0];
        default: begin
        end
      endcase
    end else if (reqDone && wb_we_i) begin
      // no byte lane given: the sampled pins still fall back into the latch
      case (regIdx)
        `GPP_IDX_FIRST_PINS:  s_d.latA = pinsIn.a;
        `GPP_IDX_SECOND_PINS: s_d.latB = pinsIn.b;
        default: begin
        end
      endcase
    end
    // reading the second port resyncs the change reference
    if (reqDone && !wb_we_i && regIdx == `GPP_IDX_SECOND_PINS) begin
      s_d.chgRef = pinsIn.b[7:4];
    end
    // events set flags over any clear in the same cycle, enables ignored
    if (count0WrapEvt) begin
      intNext[`GPP_IC_WRAP_FLAG] = 1'b1;
    end
    if (extEdge) begin
      intNext[`GPP_IC_EXT_FLAG] = 1'b1;
    end
    if (chgSeen) begin
      intNext[`GPP_IC_CHG_FLAG] = 1'b1;
    end
    s_d.intCtl = intNext;
  end

  // state register; defines every control bit after reset
  always_ff @(posedge clk) begin
    if (srst) begin
      s_q.ack       <= 1'b0;
      s_q.rdat      <= 8'h00;
      s_q.latA      <= 6'h00;
      s_q.dirA      <= `GPP_RST_FIRST_DIR;
      s_q.latB      <= 8'h00;
      s_q.dirB      <= `GPP_RST_SECOND_DIR;
      s_q.opt       <= `GPP_RST_OPTIONS;
      s_q.intCtl    <= `GPP_RST_INT_CTL;
      s_q.convCfg   <= `GPP_RST_CONV_CFG;
      s_q.periphCtl <= `GPP_RST_PERIPH_CTL;
      s_q.chgRef    <= pinsIn.b[7:4];                          // no false change after reset
      s_q.extPrev   <= pinsIn.b[0];                            // no false edge after reset
    end else begin
      s_q <= s_d;
    end
  end

  // bus answer
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = {24'h000000, s_q.rdat};

  // request needs global enable; peripheral sources also need their gate
  always_comb begin
    irqReq = s_q.intCtl[`GPP_IC_GLOBAL_EN] && (
      (s_q.intCtl[`GPP_IC_WRAP_EN] && s_q.intCtl[`GPP_IC_WRAP_FLAG]) ||
      (s_q.intCtl[`GPP_IC_EXT_EN]  && s_q.intCtl[`GPP_IC_EXT_FLAG])  ||
      (s_q.intCtl[`GPP_IC_CHG_EN]  && s_q.intCtl[`GPP_IC_CHG_FLAG])  ||
      (s_q.intCtl[`GPP_IC_PERIPH_EN] && periphIrqPend));
  end

endmodule

// File: gpp_cfg.svh
`ifndef GPP_CFG_SVH
`define GPP_CFG_SVH

// register indices; byte address is four times the index
`define GPP_IDX_FIRST_PINS   8'h05
`define GPP_IDX_SECOND_PINS  8'h06
`define GPP_IDX_INT_CTL      8'h0B
`define GPP_IDX_OPTIONS      8'h81
`define GPP_IDX_FIRST_DIR    8'h85
`define GPP_IDX_SECOND_DIR   8'h86
`define GPP_IDX_CONV_CFG     8'h9F
`define GPP_IDX_PERIPH_CTL   8'hA0

// interrupt control field positions
`define GPP_IC_GLOBAL_EN     7
`define GPP_IC_PERIPH_EN     6
`define GPP_IC_WRAP_EN       5
`define GPP_IC_EXT_EN        4
`define GPP_IC_CHG_EN        3
`define GPP_IC_WRAP_FLAG     2
`define GPP_IC_EXT_FLAG      1
`define GPP_IC_CHG_FLAG      0

// option register field positions
`define GPP_OPT_PULL_DIS_N   7
`define GPP_OPT_EDGE_SEL     6
`define GPP_OPT_COUNT_SRC    5

// peripheral control field positions
`define GPP_PC_SERIAL_EN     0

// pin roles on the first port
`define GPP_PA_COUNT_CLK     4
`define GPP_PA_SERIAL_SEL    5

// reset values
`define GPP_RST_INT_CTL      8'h00
`define GPP_RST_OPTIONS      8'hFF
`define GPP_RST_FIRST_DIR    6'h3F
`define GPP_RST_SECOND_DIR   8'hFF
`define GPP_RST_CONV_CFG     3'h0
`define GPP_RST_PERIPH_CTL   8'h00

`endif

// File: gpp_pkg.sv
package gpp_pkg;

  // pin levels seen at the package
  typedef struct packed {
    logic [5:0] a;
    logic [7:0] b;
  } gpp_pins_in_t;

  // pin drive, enables and pull-up requests
  typedef struct packed {
    logic [5:0] a;
    logic [5:0] aOe;
    logic [7:0] b;
    logic [7:0] bOe;
    logic [7:0] bPull;
  } gpp_pins_out_t;

  // whole state of the port block
  typedef struct packed {
    logic       ack;
    logic [7:0] rdat;
    logic [5:0] latA;
    logic [5:0] dirA;
    logic [7:0] latB;
    logic [7:0] dirB;
    logic [7:0] opt;
    logic [7:0] intCtl;
    logic [2:0] convCfg;
    logic [7:0] periphCtl;
    logic [3:0] chgRef;
    logic       extPrev;
  } gpp_state_t;

endpackage

// File: gpp_pin_cell.sv
`timescale 1ns/1ns
module gpp_pin_cell (
  // control
  input  wire logic dir,
  input  wire logic latch,
  input  wire logic analog,
  input  wire logic openDrain,
  input  wire logic periphOwn,
  // pin
  input  wire logic pinIn,
  output logic      pinOut,
  output logic      pinOe,
  // read path
  output logic      rdVal
);

  // driver: open drain pulls low only, an owning peripheral keeps it off
  always_comb begin
    pinOut = openDrain ? 1'b0 : latch;
    pinOe  = !dir && !periphOwn && (!openDrain || !latch);
  end

  // analog pins have the digital buffer off and read as zero
  always_comb begin
    rdVal = analog ? 1'b0 : pinIn;
  end

endmodule

// File: gpp_pin_model.sv
`timescale 1ns/1ns
module gpp_pin_model
  import gpp_pkg::*;
(
  // design drive
  input  wire gpp_pins_out_t pinsOut,
  // board levels, always driven by the board
  input  wire logic [5:0]    extA,
  input  wire logic [7:0]    extB,
  // resolved pin levels
  output gpp_pins_in_t       pinsIn
);
  // an enabled driver beats the board; a floated pin shows the board level
  always_comb begin
    for (int i = 0; i < 6; i++)
      pinsIn.a[i] = pinsOut.aOe[i] ? pinsOut.a[i] : extA[i];
    for (int i = 0; i < 8; i++)
      pinsIn.b[i] = pinsOut.bOe[i] ? pinsOut.b[i] : extB[i];
  end
endmodule

// File: gpp_top_chk.sv
`timescale 1ns/1ns
`include "gpp_cfg.svh"
module gpp_top_chk
  import gpp_pkg::*;
(
  // clock and reset
  input wire logic          clk,
  input wire logic          srst,
  // wishbone
  input wire logic          wb_cyc_i,
  input wire logic          wb_stb_i,
  input wire logic          wb_we_i,
  input wire logic [11:0]   wb_adr_i,
  input wire logic [3:0]    wb_sel_i,
  input wire logic [31:0]   wb_dat_i,
  input wire logic [31:0]   wb_dat_o,
  input wire logic          wb_ack_o,
  // pins and peripheral side
  input wire gpp_pins_in_t  pinsIn,
  input wire gpp_pins_out_t pinsOut,
  input wire logic          sharedCountClock,
  input wire logic          serialSelectN
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // request not yet answered
  logic newReq;
  // address hits the second port data register
  logic hitB;
  assign newReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign hitB = wb_adr_i[9:2] == `GPP_IDX_SECOND_PINS;
  chk_ack_timing: assert property (newReq |=> wb_ack_o) else $error("ack not one cycle after request");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held over two cycles");
  chk_read_pins: assert property (newReq && !wb_we_i && hitB |=> wb_dat_o[7:0] == $past(pinsIn.b))
    else $error("second port read is not the pin levels");
  chk_write_latch: assert property (newReq && wb_we_i && wb_sel_i[0] && hitB
    |-> ##2 (pinsOut.b & pinsOut.bOe) == ($past(wb_dat_i[7:0], 2) & pinsOut.bOe)) else $error("latch not written");
  chk_open_drain: assert property (pinsOut.a[4] == 1'b0) else $error("count clock pin driven high");
  chk_reset_float: assert property ($fell(srst) |-> pinsOut.aOe == 6'h00 && pinsOut.bOe == 8'h00)
    else $error("pins driven after reset");
  chk_pull_input: assert property ((pinsOut.bPull & pinsOut.bOe) == 8'h00 &&
    (pinsOut.bPull == 8'h00 || pinsOut.bPull == ~pinsOut.bOe)) else $error("pull-up gating wrong");
  chk_count_clock: assert property (sharedCountClock == pinsIn.a[4]) else $error("count clock not from pin");
  chk_serial_select: assert property (serialSelectN == pinsIn.a[5]) else $error("select not from pin");
  // main scenarios reached
  cover property (newReq && wb_we_i);
  cover property (pinsOut.bPull != 8'h00);
  cover property (pinsOut.aOe[4]);
endmodule

bind gpp_top gpp_top_chk chk (.clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .pinsIn(pinsIn), .pinsOut(pinsOut), .sharedCountClock(sharedCountClock),
  .serialSelectN(serialSelectN));

// File: gpp_top_tb.sv
`timescale 1ns/1ns
`include "gpp_cfg.svh"
module gpp_top_tb
  import gpp_pkg::*;
();
  // register indices
  localparam logic [7:0] aPins = `GPP_IDX_FIRST_PINS, bPins = `GPP_IDX_SECOND_PINS, icReg = `GPP_IDX_INT_CTL,
    optReg = `GPP_IDX_OPTIONS, aDir = `GPP_IDX_FIRST_DIR, bDir = `GPP_IDX_SECOND_DIR,
    cfgReg = `GPP_IDX_CONV_CFG, perReg = `GPP_IDX_PERIPH_CTL;
  logic          clk = 1'b0;     // 50 ns cycle
  logic          srst = 1'b1;    // held for 16 cycles
  logic          cyc = 1'b0;     // cyc and stb together
  logic          we = 1'b0;
  logic [11:0]   adr = 12'h000;
  logic [31:0]   wdat = 32'h0;
  logic [3:0]    sel = 4'hF;        // byte lanes on the bus
  logic [3:0]    laneSel = 4'hF;    // lanes for the next request
  logic [31:0]   rdat;
  logic          ack;
  logic          wrapEvt = 1'b0;    // one-cycle wrap pulse
  logic          periphPend = 1'b0; // other peripheral request
  logic [5:0]    extA = 6'h3F;      // board levels
  logic [7:0]    extB = 8'h00;
  gpp_pins_in_t  pinsIn;
  gpp_pins_out_t pinsOut;
  logic          irqReq;
  logic          cntClk;
  logic          selN;
  int            fails = 0;
  int            comparisons = 0;

  gpp_top dut (.clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pinsIn(pinsIn), .pinsOut(pinsOut),
    .count0WrapEvt(wrapEvt), .periphIrqPend(periphPend), .sharedCountClock(cntClk), .serialSelectN(selN),
    .irqReq(irqReq));
  gpp_pin_model board (.pinsOut(pinsOut), .extA(extA), .extB(extB), .pinsIn(pinsIn));

  // free-running clock
  initial begin
    forever #25 clk = ~clk;
  end

  // verdict and end of run
  task automatic stop_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // count and compare; an unknown never matches
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one classic cycle, held until ack is sampled high
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] r);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= {2'b00, idx, 2'b00};
    wdat <= {24'h0, d};
    sel <= laneSel;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    // a slave that never answers ends the run
    if (ack !== 1'b1) begin
      fails++;
      stop_test();
    end else begin
      r = rdat[7:0];
      cyc <= 1'b0;
      we <= 1'b0;
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] r;
    xfer(1'b1, idx, d, r);
  endtask

  task automatic rd(input string what, input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] r;
    xfer(1'b0, idx, 8'h00, r);
    check(what, r, exp);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    rd("options reset", optReg, 8'hFF);
    rd("second dir reset", bDir, 8'hFF);
    rd("int ctl reset", icReg, 8'h00);
    rd("unmapped", 8'h40, 8'h00);
    rd("first pins analog", aPins, 8'h10);
    wr(cfgReg, 8'h06);
    rd("first pins digital", aPins, 8'h3F);
    $display("test reset and analog done");
    wr(optReg, 8'h5F);
    wr(aDir, 8'h00);
    wr(aPins, 8'h2F);
    @(negedge clk);
    check("first drive", {2'b00, pinsOut.a}, 8'h2F);
    check("first enable", {2'b00, pinsOut.aOe}, 8'h3F);
    rd("first readback", aPins, 8'h2F);
    wr(aPins, 8'h3F);
    @(negedge clk);
    check("open drain released", {2'b00, pinsOut.aOe}, 8'h2F);
    wr(perReg, 8'h01);
    @(negedge clk);
    check("serial owns pin", {2'b00, pinsOut.aOe}, 8'h0F);
    wr(aDir, 8'h3F);
    @(negedge clk);
    check("first float", {2'b00, pinsOut.aOe}, 8'h00);
    // a write with no byte lane puts the sampled pins back into the latch
    @(posedge clk);
    extA <= 6'h15;
    laneSel = 4'h0;
    wr(aPins, 8'h00);
    laneSel = 4'hF;
    @(negedge clk);
    check("count clock in", {7'h0, cntClk}, 8'h01);
    check("select in", {7'h0, selN}, 8'h00);
    wr(aDir, 8'h00);
    @(negedge clk);
    check("merged latch", {2'b00, pinsOut.a}, 8'h05);
    $display("test first port done");
    wr(bDir, 8'hF0);
    wr(bPins, 8'hA5);
    @(negedge clk);
    check("pull on inputs", pinsOut.bPull, 8'hF0);
    check("second enable", pinsOut.bOe, 8'h0F);
    rd("second readback", bPins, 8'h05);
    wr(optReg, 8'hDF);
    @(negedge clk);
    check("pull off", pinsOut.bPull, 8'h00);
    wr(bDir, 8'hFF);
    $display("test second port done");
    // rising edge selected, global and ext enables set
    wr(icReg, 8'h90);
    extB <= 8'h01;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("irq raised", {7'h0, irqReq}, 8'h01);
    rd("ext flag rising", icReg, 8'h92);
    wr(icReg, 8'h10);
    extB <= 8'h00;
    repeat (3) @(posedge clk);
    rd("no flag falling", icReg, 8'h10);
    check("global off", {7'h0, irqReq}, 8'h00);
    wrapEvt <= 1'b1;
    @(posedge clk);
    wrapEvt <= 1'b0;
    rd("wrap flag", icReg, 8'h14);
    rd("second pins ref", bPins, 8'h00);
    extB <= 8'h80;
    repeat (2) @(posedge clk);
    rd("change flag", icReg, 8'h15);
    rd("second pins", bPins, 8'h80);
    wr(icReg, 8'h00);
    rd("change cleared", icReg, 8'h00);
    wr(icReg, 8'hC0);
    periphPend <= 1'b1;
    @(negedge clk);
    check("periph irq", {7'h0, irqReq}, 8'h01);
    $display("test interrupts done");
    stop_test();
  end
endmodule
